// File: common/pci_mirror_pkg.sv
package pci_mirror_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CLREV = 8'h04;
  localparam logic [7:0] OFS_LINE = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0C;
  localparam logic [7:0] OFS_IMASK = 8'h10;

  // command half field positions
  localparam int BIT_IO = 0;
  localparam int BIT_MEM = 1;
  localparam int BIT_MST = 2;
  localparam int BIT_SPC = 3;
  localparam int BIT_MWI = 4;
  localparam int BIT_PAL = 5;
  localparam int BIT_PER = 6;
  localparam int BIT_SERR = 8;
  localparam int BIT_B2B = 9;
  // status half field positions
  localparam int BIT_MPR = 24;
  localparam int BIT_SSE = 30;
  localparam int BIT_DET = 31;

  // writable command bits: 8,6,4,3,2,1
  localparam logic [31:0] CMD_WMASK = 32'h0000_015E;
  // medium decode timing hardwired as 01 in bits 26-25
  localparam logic [31:0] CMD_FIXED = 32'h0200_0000;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [31:0] CLREV_RST = 32'h0000_0000;
  localparam logic [31:0] LINE_WMASK = 32'h0000_FFFF;
  localparam logic [31:0] LINE_RST = 32'h0000_0000;

  // interrupt status / mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DET = 0;
  localparam int IRQ_SSE = 1;
  localparam int IRQ_MPR = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel, input logic [31:0] wm);
    logic [31:0] m;
    m = lane_mask(sel) & wm;
    wmerge = (old & ~m) | (nw & m);
  endfunction

endpackage

// File: logic/wb_classic_slave.sv
`timescale 1ns/10ps
`default_nettype none
module wb_classic_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] rdata_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  output logic wr_o
);
  logic ack_q;
  logic [31:0] dat_q;

  // one wait state; ack drops in the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i & stb_i & ~ack_q;
    end
  end

  // read data captured with ack so it is stable when sampled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_q) begin
      dat_q <= rdata_i;
    end
  end

  // write lands only at the edge where the master sees ack
  assign wr_o = cyc_i & stb_i & we_i & ack_q;
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_one_cycle: assert property (ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");
  chk_ack_follows_req: assert property ((cyc_i && stb_i && !ack_q) |=> ack_q)
    else $error("request not acknowledged next cycle");
endmodule
`default_nettype wire

// File: logic/parity_error_unit.sv
`timescale 1ns/10ps
`default_nettype none
module parity_error_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic par_err_i,
  input wire logic sys_err_i,
  input wire logic master_active_i,
  input wire logic perr_pin_n_i,
  input wire logic par_resp_en_i,
  input wire logic serr_en_i,
  output logic perr_pin_o,
  output logic perr_oe_o,
  output logic serr_pin_o,
  output logic serr_oe_o,
  output logic det_o,
  output logic sse_o,
  output logic mpr_o
);
  logic perr_oe_q, serr_oe_q, det_q, mpr_q, pin_low;

  assign pin_low = ~perr_pin_n_i;

  // open drain: level is always low, the enable carries the event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      perr_oe_q <= 1'b0;
    end else begin
      perr_oe_q <= par_err_i & par_resp_en_i; // RQ3 RQ4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serr_oe_q <= 1'b0;
    end else begin
      serr_oe_q <= sys_err_i & serr_en_i; // RQ2
    end
  end

  // detection is flagged even with the response disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_q <= 1'b0;
      mpr_q <= 1'b0;
    end else begin
      det_q <= par_err_i; // RQ14
      mpr_q <= par_resp_en_i & master_active_i & ((par_err_i & par_resp_en_i) | pin_low); // RQ15
    end
  end

  assign perr_pin_o = 1'b0;
  assign serr_pin_o = 1'b0;
  assign perr_oe_o = perr_oe_q;
  assign serr_oe_o = serr_oe_q;
  assign det_o = det_q;
  assign sse_o = serr_oe_q;
  assign mpr_o = mpr_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence err_responded;
    par_err_i && par_resp_en_i;
  endsequence
  sequence err_silent;
    par_err_i && !par_resp_en_i;
  endsequence

  chk_perr_drive: assert property (err_responded |=> perr_oe_o && det_o) // RQ3
    else $error("parity pin not driven with response enabled");
  chk_perr_quiet: assert property (err_silent |=> !perr_oe_o && det_o) // RQ4
    else $error("parity pin driven with response disabled");
  chk_serr_gate: assert property (serr_oe_o |-> $past(serr_en_i) && $past(sys_err_i)) // RQ2
    else $error("system error pin driven while disabled");
  chk_mpr_cause: assert property (mpr_o |-> $past(par_resp_en_i) && $past(master_active_i)) // RQ15
    else $error("master parity flag set without its conditions");
endmodule
`default_nettype wire

// File: logic/pci_config_mirror_regs.sv
// Summary of operation
// RQ1 - fast back-to-back enable bit 9 reads zero; never used
// RQ2 - system error pin driven only while system error drive enable is set
// RQ3 - parity response enable set: parity error pin driven on detected errors
// RQ4 - parity response disabled: flag still set, pin not driven, operation continues
// RQ5 - palette snoop bit 5 reads zero, no snooping
// RQ6 - write-and-invalidate used only while its enable bit 4 is set
// RQ7 - special cycles ignored unless special cycle enable bit 3 set
// RQ8 - bus mastering only while master enable bit 2 set
// RQ9 - memory accesses claimed only while memory space enable bit 1 set
// RQ10 - io space enable bit 0 reads zero; io never claimed
// RQ11 - loader writes class and revision mirror before configuration access opens
// RQ12 - class code bits 31-8 and revision bits 7-0 are read/write
// RQ13 - self-test and header bytes read zero; latency and line bytes writable
// RQ14 - detected parity flag bit 31 set on every detected parity error
// RQ15 - master parity flag bit 24 needs response enable, pin and mastership
// RQ16 - writes to fixed or reserved command/status bits are ignored
`timescale 1ns/10ps
`default_nettype none
module pci_config_mirror_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  input wire logic parity_error_detect_i,
  input wire logic system_error_event_i,
  input wire logic master_active_i,
  input wire logic parity_error_pin_n_i,
  output logic parity_error_pin_o,
  output logic parity_error_pin_oe_o,
  output logic system_error_pin_o,
  output logic system_error_pin_oe_o,
  input wire logic master_request_i,
  input wire logic write_invalidate_request_i,
  input wire logic special_cycle_i,
  input wire logic memory_hit_i,
  input wire logic io_hit_i,
  output logic master_request_o,
  output logic write_invalidate_o,
  output logic special_cycle_accept_o,
  output logic memory_claim_o,
  output logic io_claim_o,
  output logic back_to_back_o,
  output logic [31:0] config_class_revision_o,
  output logic [7:0] latency_timer_o,
  output logic [7:0] cache_line_words_o
);
  if (ADDR_W < 5) begin : g_chk
    $error("ADDR_W too small for register map");
  end

  logic [31:0] ctl_q, ctl_d;
  logic [31:0] clrev_q;
  logic [15:0] line_q;
  logic det_q, sse_q, mpr_q;
  logic [pci_mirror_pkg::IRQ_W-1:0] istat_q, imask_q, ev;
  logic irq_q;
  logic mreq_q, mwi_q, spc_q, mem_q, io_q, b2b_q;
  logic wr, wr_cmd, wr_clrev, wr_line, wr_istat, wr_imask;
  logic [7:0] a8;
  logic [31:0] cmd_rd, rd_d, clr;
  logic ev_det, ev_sse, ev_mpr;

  wb_classic_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .rdata_i(rd_d),
    .ack_o(ack_o),
    .dat_o(dat_o),
    .wr_o(wr)
  );

  parity_error_unit u_err (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .par_err_i(parity_error_detect_i),
    .sys_err_i(system_error_event_i),
    .master_active_i(master_active_i),
    .perr_pin_n_i(parity_error_pin_n_i),
    .par_resp_en_i(ctl_q[pci_mirror_pkg::BIT_PER]),
    .serr_en_i(ctl_q[pci_mirror_pkg::BIT_SERR]),
    .perr_pin_o(parity_error_pin_o),
    .perr_oe_o(parity_error_pin_oe_o),
    .serr_pin_o(system_error_pin_o),
    .serr_oe_o(system_error_pin_oe_o),
    .det_o(ev_det),
    .sse_o(ev_sse),
    .mpr_o(ev_mpr)
  );

  // upper address bits beyond the map alias nothing: unmapped reads zero
  if (ADDR_W > 8) begin : g_wide_adr
    // 8'hFF is no register offset, so any high bit lands in the default arm
    assign a8 = (|adr_i[ADDR_W-1:8]) ? 8'hFF : adr_i[7:0];
  end else begin : g_narrow_adr
    assign a8 = 8'(adr_i);
  end
  assign wr_cmd = wr && (a8 == pci_mirror_pkg::OFS_CMD);
  assign wr_clrev = wr && (a8 == pci_mirror_pkg::OFS_CLREV);
  assign wr_line = wr && (a8 == pci_mirror_pkg::OFS_LINE);
  assign wr_istat = wr && (a8 == pci_mirror_pkg::OFS_ISTAT);
  assign wr_imask = wr && (a8 == pci_mirror_pkg::OFS_IMASK);
  assign clr = dat_i & pci_mirror_pkg::lane_mask(sel_i);

  // only the documented enables can ever hold a one
  assign ctl_d = pci_mirror_pkg::wmerge(ctl_q, dat_i, sel_i, pci_mirror_pkg::CMD_WMASK); // RQ16

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= pci_mirror_pkg::CMD_RST;
    end else if (wr_cmd) begin
      ctl_q <= ctl_d; // RQ1 RQ5 RQ10 RQ16
    end
  end

  // status flags: write one to clear, a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_q <= 1'b0;
      sse_q <= 1'b0;
      mpr_q <= 1'b0;
    end else begin
      det_q <= ev_det | (det_q & ~(wr_cmd & clr[pci_mirror_pkg::BIT_DET])); // RQ14
      sse_q <= ev_sse | (sse_q & ~(wr_cmd & clr[pci_mirror_pkg::BIT_SSE]));
      mpr_q <= ev_mpr | (mpr_q & ~(wr_cmd & clr[pci_mirror_pkg::BIT_MPR])); // RQ15
    end
  end

  // contents nominally undefined after reset; cleared for determinism
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clrev_q <= pci_mirror_pkg::CLREV_RST;
    end else if (wr_clrev) begin
      clrev_q <= pci_mirror_pkg::wmerge(clrev_q, dat_i, sel_i, 32'hFFFF_FFFF); // RQ12
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_q <= pci_mirror_pkg::LINE_RST[15:0];
    end else if (wr_line) begin
      line_q <= 16'(pci_mirror_pkg::wmerge({16'h0000, line_q}, dat_i, sel_i,
                                           pci_mirror_pkg::LINE_WMASK)); // RQ13
    end
  end

  assign ev = {ev_mpr, ev_sse, ev_det};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_q <= pci_mirror_pkg::IRQ_RST;
    end else begin
      istat_q <= ev | (istat_q & ~({pci_mirror_pkg::IRQ_W{wr_istat}} &
                                   clr[pci_mirror_pkg::IRQ_W-1:0]));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_q <= pci_mirror_pkg::IRQ_RST;
    end else if (wr_imask && sel_i[0]) begin
      imask_q <= dat_i[pci_mirror_pkg::IRQ_W-1:0];
    end
  end

  // registered so the pin is glitch free; one cycle behind status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & imask_q);
    end
  end

  // back-end gating, one flop so every pin is registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mreq_q <= 1'b0;
      mwi_q <= 1'b0;
      spc_q <= 1'b0;
      mem_q <= 1'b0;
      io_q <= 1'b0;
      b2b_q <= 1'b0;
    end else begin
      mreq_q <= master_request_i & ctl_q[pci_mirror_pkg::BIT_MST]; // RQ8
      mwi_q <= write_invalidate_request_i & ctl_q[pci_mirror_pkg::BIT_MWI]
               & ctl_q[pci_mirror_pkg::BIT_MST]; // RQ6
      spc_q <= special_cycle_i & ctl_q[pci_mirror_pkg::BIT_SPC]; // RQ7
      mem_q <= memory_hit_i & ctl_q[pci_mirror_pkg::BIT_MEM]; // RQ9
      io_q <= io_hit_i & ctl_q[pci_mirror_pkg::BIT_IO]; // RQ10
      b2b_q <= ctl_q[pci_mirror_pkg::BIT_B2B]; // RQ1
    end
  end

  always_comb begin
    cmd_rd = (ctl_q & pci_mirror_pkg::CMD_WMASK) | pci_mirror_pkg::CMD_FIXED; // RQ16
    cmd_rd[pci_mirror_pkg::BIT_DET] = det_q;
    cmd_rd[pci_mirror_pkg::BIT_SSE] = sse_q;
    cmd_rd[pci_mirror_pkg::BIT_MPR] = mpr_q;
  end

  always_comb begin
    unique case (a8)
      pci_mirror_pkg::OFS_CMD: rd_d = cmd_rd;
      pci_mirror_pkg::OFS_CLREV: rd_d = clrev_q;
      pci_mirror_pkg::OFS_LINE: rd_d = {16'h0000, line_q}; // RQ13
      pci_mirror_pkg::OFS_ISTAT: rd_d = {29'h0000_0000, istat_q};
      pci_mirror_pkg::OFS_IMASK: rd_d = {29'h0000_0000, imask_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // header mirror valid only once the loader has written it first
  assign config_class_revision_o = clrev_q; // RQ11
  assign latency_timer_o = line_q[15:8];
  assign cache_line_words_o = line_q[7:0];
  assign irq_o = irq_q;
  assign master_request_o = mreq_q;
  assign write_invalidate_o = mwi_q;
  assign special_cycle_accept_o = spc_q;
  assign memory_claim_o = mem_q;
  assign io_claim_o = io_q;
  assign back_to_back_o = b2b_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence full_word_write(logic [7:0] ofs);
    wr && (a8 == ofs) && (sel_i == 4'hF);
  endsequence

  chk_b2b_zero: assert property (!back_to_back_o && !cmd_rd[pci_mirror_pkg::BIT_B2B]) // RQ1
    else $error("fast back-to-back bit not zero");
  chk_pal_zero: assert property (!cmd_rd[pci_mirror_pkg::BIT_PAL]) // RQ5
    else $error("palette snoop bit not zero");
  chk_io_never: assert property (!io_claim_o && !cmd_rd[pci_mirror_pkg::BIT_IO]) // RQ10
    else $error("io space claimed or enabled");
  chk_master_gate: assert property (master_request_o |-> $past(ctl_q[pci_mirror_pkg::BIT_MST])) // RQ8
    else $error("master request without master enable");
  chk_mwi_gate: assert property (write_invalidate_o |-> $past(ctl_q[pci_mirror_pkg::BIT_MWI])) // RQ6
    else $error("write-invalidate without enable");
  chk_spc_gate: assert property ((special_cycle_i && !ctl_q[pci_mirror_pkg::BIT_SPC])
                                 |=> !special_cycle_accept_o) // RQ7
    else $error("special cycle taken while disabled");
  chk_mem_gate: assert property ((memory_hit_i && ctl_q[pci_mirror_pkg::BIT_MEM])
                                 |=> memory_claim_o) // RQ9
    else $error("memory hit not claimed while enabled");
  chk_det_flag: assert property (parity_error_detect_i |-> ##2 cmd_rd[pci_mirror_pkg::BIT_DET]) // RQ14
    else $error("detected parity flag not set");
  chk_fixed_bits: assert property (cmd_rd[26:25] == 2'b01 && cmd_rd[23:10] == 14'h0000
                                   && !cmd_rd[7]) // RQ16
    else $error("fixed command/status bits changed");
  chk_clrev_write: assert property (full_word_write(pci_mirror_pkg::OFS_CLREV)
                                    |=> clrev_q == $past(dat_i)) // RQ12
    else $error("class/revision write not stored");
  chk_line_upper: assert property (full_word_write(pci_mirror_pkg::OFS_LINE)
                                   |=> line_q == $past(dat_i[15:0]) && rd_d[31:16] == 16'h0000) // RQ13
    else $error("line register write wrong");
  chk_irq_level: assert property (|(istat_q & imask_q) |=> irq_o)
    else $error("interrupt not raised");
  chk_irq_quiet: assert property (!(|(istat_q & imask_q)) |=> !irq_o)
    else $error("interrupt raised with nothing pending");

  // a clear that meets a new event in one cycle must lose
  sequence det_event_vs_clear;
    ev_det && wr_cmd && clr[pci_mirror_pkg::BIT_DET];
  endsequence
  sequence det_clear_alone;
    !ev_det && wr_cmd && clr[pci_mirror_pkg::BIT_DET];
  endsequence

  chk_det_set_wins: assert property (det_event_vs_clear |=> det_q) // RQ14
    else $error("parity flag lost to a same-cycle clear");
  chk_det_w1c: assert property (det_clear_alone |=> !det_q) // RQ14
    else $error("parity flag not cleared by a written one");
  chk_istat_sticky: assert property ((|ev) |=> ((istat_q & $past(ev)) == $past(ev)))
    else $error("interrupt status missed an event");
  chk_ctl_mask: assert property ((ctl_q & ~pci_mirror_pkg::CMD_WMASK) == 32'h0000_0000) // RQ16
    else $error("fixed command bit took a one");
  chk_ctl_hold: assert property (!wr_cmd |=> $stable(ctl_q)) // RQ16
    else $error("command enables changed without a write");
  chk_clrev_hold: assert property (!wr_clrev |=> $stable(clrev_q)) // RQ12
    else $error("class/revision changed without a write");
  chk_line_hold: assert property (!wr_line |=> $stable(line_q)) // RQ13
    else $error("line register changed without a write");
  chk_mem_quiet: assert property (memory_claim_o // RQ9
                                  |-> $past(ctl_q[pci_mirror_pkg::BIT_MEM]))
    else $error("memory claimed while disabled");
  chk_spc_cause: assert property (special_cycle_accept_o // RQ7
                                  |-> $past(ctl_q[pci_mirror_pkg::BIT_SPC]))
    else $error("special cycle accepted while disabled");
endmodule
`default_nettype wire

// File: sim/pci_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// bus-side view of the two open-drain error pins
module pci_far_side (
  input wire logic clk_i,
  input wire logic parity_error_pin_i,
  input wire logic parity_error_pin_oe_i,
  input wire logic system_error_pin_i,
  input wire logic system_error_pin_oe_i,
  output logic parity_error_pin_n_o,
  output logic [7:0] system_error_seen_o
);
  // pull-up: a released pin reads high, never the last driven level
  assign parity_error_pin_n_o = parity_error_pin_oe_i ? parity_error_pin_i : 1'b1;
  logic [7:0] seen_q = 8'h00;
  // counts cycles in which the system error pin is pulled low
  always @(posedge clk_i) begin
    if (system_error_pin_oe_i && !system_error_pin_i) begin
      seen_q <= seen_q + 8'h01;
    end
  end
  assign system_error_seen_o = seen_q;
endmodule
`default_nettype wire

// File: sim/pci_config_mirror_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pci_config_mirror_regs_bench;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h00, lat_o, cl_o, seen;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, ccr_o, q, cmd_m = 32'h0200_0000, clrev_m = 0, line_m = 0, m;
  logic ack_o, irq_o, det_ev = 0, sys_ev = 0, mst_act = 0, ppn, ppo, ppoe, spo, spoe;
  logic [4:0] req = 5'h0;
  logic [5:0] gate_o;
  logic [2:0] istat_m = 0, imask_m = 0;
  integer seed = 81738, n_mismatch = 0, n_compared = 0, i;
  always #2 clk_i = ~clk_i;
  pci_config_mirror_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .parity_error_detect_i(det_ev), .system_error_event_i(sys_ev),
    .master_active_i(mst_act), .parity_error_pin_n_i(ppn), .parity_error_pin_o(ppo),
    .parity_error_pin_oe_o(ppoe), .system_error_pin_o(spo), .system_error_pin_oe_o(spoe),
    .master_request_i(req[4]), .write_invalidate_request_i(req[3]), .special_cycle_i(req[2]),
    .memory_hit_i(req[1]), .io_hit_i(req[0]), .master_request_o(gate_o[5]),
    .write_invalidate_o(gate_o[4]), .special_cycle_accept_o(gate_o[3]),
    .memory_claim_o(gate_o[2]), .io_claim_o(gate_o[1]), .back_to_back_o(gate_o[0]),
    .config_class_revision_o(ccr_o), .latency_timer_o(lat_o), .cache_line_words_o(cl_o));
  pci_far_side far (.clk_i(clk_i), .parity_error_pin_i(ppo), .parity_error_pin_oe_i(ppoe),
    .system_error_pin_i(spo), .system_error_pin_oe_i(spoe), .parity_error_pin_n_o(ppn),
    .system_error_seen_o(seen));

  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: exp_rd = cmd_m;
      8'h04: exp_rd = clrev_m;
      8'h08: exp_rd = line_m;
      8'h0C: exp_rd = {29'h0, istat_m};
      8'h10: exp_rd = {29'h0, imask_m};
      default: exp_rd = 32'h0;
    endcase
  endfunction

  // classic single cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    integer k;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    check("ack", 32'h1, {31'h0, ack_o});
  endtask

  task rd(input logic [7:0] a);
    wb(0, a, 4'hF, 32'h0);
    check("read", exp_rd(a), q);
  endtask

  task wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    wb(1, a, s, d);
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    // status bits 31,30,24 clear on a written one
    if (a == 8'h00) cmd_m = ((cmd_m & ~(m & 32'h0000_015E)) | (d & m & 32'h0000_015E))
      & ~(d & m & 32'hC100_0000);
    if (a == 8'h04) clrev_m = (clrev_m & ~m) | (d & m);
    if (a == 8'h08) line_m = (line_m & ~(m & 32'hFFFF)) | (d & m & 32'hFFFF);
    if (a == 8'h0C && s[0]) istat_m = istat_m & ~d[2:0];
    if (a == 8'h10 && s[0]) imask_m = d[2:0];
  endtask

  task fire(input logic par);
    logic oe;
    logic [7:0] s0;
    oe = par ? cmd_m[6] : cmd_m[8];
    s0 = seen;
    @(posedge clk_i);
    det_ev <= par;
    sys_ev <= !par;
    @(posedge clk_i);
    det_ev <= 0;
    sys_ev <= 0;
    @(posedge clk_i);
    check("perr oe", {31'h0, par & oe}, {31'h0, ppoe});
    check("perr wire", {31'h0, !(par & oe)}, {31'h0, ppn});
    check("serr oe", {31'h0, !par & oe}, {31'h0, spoe});
    repeat (3) @(posedge clk_i);
    check("serr wire", {24'h0, s0 + {7'h0, !par & oe}}, {24'h0, seen});
    if (par) cmd_m[31] = 1;
    if (par) istat_m[0] = 1;
    if (par & cmd_m[6] & mst_act) cmd_m[24] = 1;
    if (par & cmd_m[6] & mst_act) istat_m[2] = 1;
    if (!par & oe) cmd_m[30] = 1;
    if (!par & oe) istat_m[1] = 1;
    check("irq", {31'h0, |(istat_m & imask_m)}, {31'h0, irq_o});
  endtask

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #40000;
    n_mismatch++;
    wrap_up;
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 6; i++) rd(8'(4 * i));
    check("gates", 32'h0, {26'h0, gate_o});
    $display("test reset done");
    // loader fills the mirror before any command bit is enabled
    wr(8'h04, 4'hF, $random(seed));
    for (i = 0; i < 6; i++) begin
      wr(8'h04, 4'($random(seed)), $random(seed));
      rd(8'h04);
    end
    wr(8'h08, 4'hF, 32'hFFFF_FFFF);
    rd(8'h08);
    wr(8'h14, 4'hF, 32'hFFFF_FFFF);
    rd(8'h14);
    check("mirror out", clrev_m, ccr_o);
    check("line out", line_m[15:0], {16'h0, lat_o, cl_o});
    $display("test mirror done");
    for (i = 0; i < 12; i++) begin
      wr(8'h00, 4'($random(seed)), $random(seed));
      rd(8'h00);
      @(posedge clk_i);
      req <= 5'($random(seed));
      repeat (2) @(posedge clk_i);
      check("gates", {26'h0, req[4] & cmd_m[2], req[3] & cmd_m[4] & cmd_m[2],
        req[2] & cmd_m[3], req[1] & cmd_m[1], 2'b00}, {26'h0, gate_o});
    end
    $display("test command done");
    for (i = 0; i < 4; i++) begin
      wr(8'h10, 4'h1, (i == 3) ? 32'h0 : 32'h7);
      wr(8'h00, 4'hF, {23'h0, i[1], 1'b0, i[0], 6'h00});
      mst_act <= i[0];
      fire(1);
      fire(0);
      rd(8'h00);
      rd(8'h0C);
      wr(8'h0C, 4'h1, 32'h7);
      wr(8'h00, 4'h8, 32'hC100_0000);
      rd(8'h00);
      check("irq", 32'h0, {31'h0, irq_o});
    end
    $display("test errors done");
    wrap_up;
  end
endmodule
`default_nettype wire
